// file: rtl/rx_desc_pkg.sv
/*
 * Constants and types shared by the receive descriptor-list DMA:
 * register offsets, control bits, descriptor word layout, states.
 * Assumes a 32-bit APB register bus and a 32-bit host memory port.
 */
package rx_desc_pkg;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] ctrl_off          = 8'h00;
    localparam logic [7:0] rx_list_base_off  = 8'h04;
    localparam logic [7:0] tx_list_base_off  = 8'h08;
    localparam logic [7:0] status_off        = 8'h0c;
    localparam logic [7:0] poll_off          = 8'h10;
    localparam logic [7:0] cur_desc_off      = 8'h14;
    localparam logic [7:0] frame_count_off   = 8'h18;

    // Control register bits
    localparam int ctrl_rx_enable_bit        = 0;
    localparam int ctrl_chain_enable_bit     = 1;

    // Status register bits
    localparam int stat_active_bit           = 0;
    localparam int stat_waiting_bit          = 1;
    localparam int stat_first_pending_bit    = 2;

    // ************************************************************
    // Descriptor layout
    // ************************************************************
    localparam logic [31:0] desc_word0_off   = 32'h0000_0000;
    localparam logic [31:0] desc_word1_off   = 32'h0000_0004;
    localparam logic [31:0] desc_word2_off   = 32'h0000_0008;
    localparam logic [31:0] desc_word3_off   = 32'h0000_000c;
    localparam int own_bit                   = 31;
    localparam int first_buffer_bit          = 30;
    localparam int last_buffer_bit           = 29;
    localparam int ip_bad_bit                = 28;
    localparam int tcp_bad_bit               = 27;
    localparam int size_width                = 11;
    localparam int word_bytes                = 4;

    // ************************************************************
    // Engine states
    // ************************************************************
    typedef enum logic [3:0] {
        st_idle,
        st_fetch0,
        st_fetch1,
        st_fetch2,
        st_fetch3,
        st_decide,
        st_data,
        st_write,
        st_drop,
        st_close,
        st_wait_own
    } state_t;

endpackage

// file: rtl/rx_descriptor_list_dma.sv
/*
 * Receive descriptor-list DMA engine with APB register slave.
 * Walks a forward-linked receive descriptor ring in host physical
 * memory, fills buffers from a word stream and hands descriptors
 * back. Assumes a host memory port that holds req until ack, and a
 * frame source whose valid stays high until accepted.
 */
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/10ps

module rx_descriptor_list_dma (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Host memory master
    output logic             mem_req,
    output logic             mem_we,
    output logic      [31:0] mem_addr,
    output logic      [31:0] mem_wdata,
    input  wire logic        mem_ack,
    input  wire logic [31:0] mem_rdata,
    // Received frame word stream
    input  wire logic        rx_valid,
    output logic             rx_ready,
    input  wire logic [31:0] rx_data,
    input  wire logic        rx_last,
    input  wire logic        rx_ip_checksum_bad,
    input  wire logic        rx_tcp_checksum_bad
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        rx_desc_pkg::state_t               state;
        logic                              rx_enable;
        logic                              chain_enable;
        logic [31:0]                       rx_list_base;
        logic [31:0]                       tx_list_base;
        logic [31:0]                       desc_addr;
        logic [31:0]                       buf_addr;
        logic [31:0]                       next_addr;
        logic [rx_desc_pkg::size_width-1:0] buf_bytes;
        logic [rx_desc_pkg::size_width-1:0] byte_cnt;
        logic                              first_pending;
        logic                              first_buffer_flag;
        logic                              last_buffer_flag;
        logic                              ip_checksum_bad;
        logic                              tcp_checksum_bad;
        logic                              poll;
        logic [31:0]                       frame_count;
        logic                              mem_req;
        logic                              mem_we;
        logic [31:0]                       mem_addr;
        logic [31:0]                       mem_wdata;
        logic                              rx_ready;
        logic [31:0]                       prdata;
        logic                              pready;
        logic                              pslverr;
    } dma_state_t;

    dma_state_t cur;
    dma_state_t next_cur;

    logic                               apb_access;
    logic                               apb_write;
    logic                               room;
    logic [rx_desc_pkg::size_width:0]   fill_after;
    logic [31:0]                        close_word;
    logic [31:0]                        status_word;

    localparam logic [rx_desc_pkg::size_width-1:0] size_zero = '0;
    localparam logic [rx_desc_pkg::size_width-1:0] word_step =
        rx_desc_pkg::size_width'(rx_desc_pkg::word_bytes);

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        next_cur    = cur;
        apb_access  = psel && penable && !cur.pready;
        apb_write   = psel && penable && cur.pready && pwrite;
        fill_after  = {1'b0, cur.byte_cnt} + {1'b0, word_step};
        room        = (fill_after <= {1'b0, cur.buf_bytes});

        // Ownership clear and status flags go out in one write
        close_word                                = '0;
        close_word[rx_desc_pkg::own_bit]          = 1'b0;
        close_word[rx_desc_pkg::first_buffer_bit] = cur.first_buffer_flag;
        close_word[rx_desc_pkg::last_buffer_bit]  = cur.last_buffer_flag;
        close_word[rx_desc_pkg::ip_bad_bit]       = cur.last_buffer_flag && cur.ip_checksum_bad;
        close_word[rx_desc_pkg::tcp_bad_bit]      = cur.last_buffer_flag && cur.tcp_checksum_bad;

        status_word = '0;
        status_word[rx_desc_pkg::stat_active_bit]        = (cur.state != rx_desc_pkg::st_idle) &&
                                                           (cur.state != rx_desc_pkg::st_wait_own);
        status_word[rx_desc_pkg::stat_waiting_bit]       = (cur.state == rx_desc_pkg::st_wait_own);
        status_word[rx_desc_pkg::stat_first_pending_bit] = cur.first_pending;

        // ********************************************************
        // APB slave: one wait state, answer registered
        // ********************************************************
        next_cur.pready  = apb_access;
        next_cur.pslverr = 1'b0;
        next_cur.prdata  = '0;
        if (apb_access) begin
            case (paddr)
                rx_desc_pkg::ctrl_off: begin
                    next_cur.prdata[rx_desc_pkg::ctrl_rx_enable_bit]    = cur.rx_enable;
                    next_cur.prdata[rx_desc_pkg::ctrl_chain_enable_bit] = cur.chain_enable;
                end
                rx_desc_pkg::rx_list_base_off: next_cur.prdata = cur.rx_list_base;
                rx_desc_pkg::tx_list_base_off: next_cur.prdata = cur.tx_list_base;
                rx_desc_pkg::status_off:       next_cur.prdata = status_word;
                rx_desc_pkg::poll_off:         next_cur.prdata = '0;
                rx_desc_pkg::cur_desc_off:     next_cur.prdata = cur.desc_addr;
                rx_desc_pkg::frame_count_off:  next_cur.prdata = cur.frame_count;
                default:                       next_cur.pslverr = 1'b1;
            endcase
        end
        if (apb_write) begin
            case (paddr)
                rx_desc_pkg::ctrl_off: begin
                    next_cur.rx_enable    = pwdata[rx_desc_pkg::ctrl_rx_enable_bit];
                    next_cur.chain_enable = pwdata[rx_desc_pkg::ctrl_chain_enable_bit];
                end
                rx_desc_pkg::rx_list_base_off: begin
                    next_cur.rx_list_base = pwdata;
                    next_cur.desc_addr    = pwdata;
                end
                rx_desc_pkg::tx_list_base_off: next_cur.tx_list_base = pwdata;
                rx_desc_pkg::poll_off:         next_cur.poll         = 1'b1;
                default: begin
                end
            endcase
        end

        // ********************************************************
        // Descriptor engine
        // ********************************************************
        case (cur.state)
            rx_desc_pkg::st_idle: begin
                if (cur.rx_enable) begin
                    next_cur.state    = rx_desc_pkg::st_fetch0;
                    next_cur.mem_req  = 1'b1;
                    next_cur.mem_we   = 1'b0;
                    next_cur.mem_addr = cur.desc_addr + rx_desc_pkg::desc_word0_off;
                end
            end
            rx_desc_pkg::st_fetch0: begin
                if (mem_ack) begin
                    if (mem_rdata[rx_desc_pkg::own_bit]) begin
                        next_cur.state    = rx_desc_pkg::st_fetch1;
                        next_cur.mem_addr = cur.desc_addr + rx_desc_pkg::desc_word1_off;
                    end else begin
                        next_cur.state   = rx_desc_pkg::st_wait_own;
                        next_cur.mem_req = 1'b0;
                        // A poll landing in this very cycle must not be lost
                        next_cur.poll    = apb_write && (paddr == rx_desc_pkg::poll_off);
                    end
                end
            end
            rx_desc_pkg::st_fetch1: begin
                if (mem_ack) begin
                    next_cur.buf_bytes = mem_rdata[rx_desc_pkg::size_width-1:0];
                    next_cur.state     = rx_desc_pkg::st_fetch2;
                    next_cur.mem_addr  = cur.desc_addr + rx_desc_pkg::desc_word2_off;
                end
            end
            rx_desc_pkg::st_fetch2: begin
                if (mem_ack) begin
                    next_cur.buf_addr = mem_rdata;
                    next_cur.state    = rx_desc_pkg::st_fetch3;
                    next_cur.mem_addr = cur.desc_addr + rx_desc_pkg::desc_word3_off;
                end
            end
            rx_desc_pkg::st_fetch3: begin
                if (mem_ack) begin
                    next_cur.next_addr = mem_rdata;
                    next_cur.mem_req   = 1'b0;
                    next_cur.state     = rx_desc_pkg::st_decide;
                end
            end
            rx_desc_pkg::st_decide: begin
                next_cur.byte_cnt          = size_zero;
                next_cur.first_buffer_flag = 1'b0;
                next_cur.last_buffer_flag  = 1'b0;
                next_cur.ip_checksum_bad   = 1'b0;
                next_cur.tcp_checksum_bad  = 1'b0;
                if (cur.first_pending && cur.buf_bytes == size_zero) begin
                    // Empty first buffer: hand it back, frame starts in the next one
                    next_cur.state     = rx_desc_pkg::st_close;
                    next_cur.mem_req   = 1'b1;
                    next_cur.mem_we    = 1'b1;
                    next_cur.mem_addr  = cur.desc_addr + rx_desc_pkg::desc_word0_off;
                    next_cur.mem_wdata = '0;
                end else begin
                    next_cur.first_buffer_flag = cur.first_pending;
                    next_cur.state             = rx_desc_pkg::st_data;
                end
            end
            rx_desc_pkg::st_data: begin
                if (cur.rx_ready) begin
                    // Word taken at this edge; write it into the buffer
                    next_cur.rx_ready         = 1'b0;
                    next_cur.mem_req          = 1'b1;
                    next_cur.mem_we           = 1'b1;
                    next_cur.mem_addr         = cur.buf_addr + 32'(cur.byte_cnt);
                    next_cur.mem_wdata        = rx_data;
                    next_cur.last_buffer_flag = rx_last;
                    next_cur.ip_checksum_bad  = rx_last && rx_ip_checksum_bad;
                    next_cur.tcp_checksum_bad = rx_last && rx_tcp_checksum_bad;
                    next_cur.state            = rx_desc_pkg::st_write;
                end else if (!room) begin
                    if (cur.chain_enable) begin
                        // Buffer full, frame continues in the next descriptor
                        next_cur.state     = rx_desc_pkg::st_close;
                        next_cur.mem_req   = 1'b1;
                        next_cur.mem_we    = 1'b1;
                        next_cur.mem_addr  = cur.desc_addr + rx_desc_pkg::desc_word0_off;
                        next_cur.mem_wdata = close_word;
                    end else begin
                        // No chaining: the rest of the frame is discarded
                        next_cur.state    = rx_desc_pkg::st_drop;
                        next_cur.rx_ready = 1'b1;
                    end
                end else if (rx_valid) begin
                    next_cur.rx_ready = 1'b1;
                end
            end
            rx_desc_pkg::st_write: begin
                if (mem_ack) begin
                    next_cur.mem_req  = 1'b0;
                    next_cur.byte_cnt = fill_after[rx_desc_pkg::size_width-1:0];
                    if (cur.last_buffer_flag) begin
                        next_cur.state     = rx_desc_pkg::st_close;
                        next_cur.mem_req   = 1'b1;
                        next_cur.mem_addr  = cur.desc_addr + rx_desc_pkg::desc_word0_off;
                        next_cur.mem_wdata = close_word;
                    end else begin
                        next_cur.state = rx_desc_pkg::st_data;
                    end
                end
            end
            rx_desc_pkg::st_drop: begin
                if (rx_valid && rx_last && cur.rx_ready) begin
                    next_cur.rx_ready                                    = 1'b0;
                    next_cur.last_buffer_flag                            = 1'b1;
                    next_cur.state                                       = rx_desc_pkg::st_close;
                    next_cur.mem_req                                     = 1'b1;
                    next_cur.mem_we                                      = 1'b1;
                    next_cur.mem_addr                                    = cur.desc_addr;
                    next_cur.mem_wdata                                   = close_word;
                    next_cur.mem_wdata[rx_desc_pkg::last_buffer_bit]     = 1'b1;
                    next_cur.mem_wdata[rx_desc_pkg::ip_bad_bit]          = rx_ip_checksum_bad;
                    next_cur.mem_wdata[rx_desc_pkg::tcp_bad_bit]         = rx_tcp_checksum_bad;
                end
            end
            rx_desc_pkg::st_close: begin
                if (mem_ack) begin
                    next_cur.mem_req   = 1'b0;
                    next_cur.mem_we    = 1'b0;
                    next_cur.desc_addr = cur.next_addr;
                    if (cur.first_pending && cur.buf_bytes == size_zero) begin
                        next_cur.first_pending = 1'b1;
                    end else begin
                        next_cur.first_pending = cur.last_buffer_flag;
                    end
                    if (cur.last_buffer_flag) begin
                        next_cur.frame_count = cur.frame_count + 32'h0000_0001;
                    end
                    next_cur.state = rx_desc_pkg::st_idle;
                end
            end
            rx_desc_pkg::st_wait_own: begin
                // Host still owns the descriptor; re-read on a poll, or go back to idle when rx_enable is cleared
                if (cur.poll) begin
                    next_cur.poll  = 1'b0;
                    next_cur.state = rx_desc_pkg::st_idle;
                end else if (!cur.rx_enable) begin
                    next_cur.state = rx_desc_pkg::st_idle;
                end
            end
            default: begin
                next_cur.state   = rx_desc_pkg::st_idle;
                next_cur.mem_req = 1'b0;
            end
        endcase
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur               <= '0;
            cur.state         <= rx_desc_pkg::st_idle;
            cur.first_pending <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign prdata    = cur.prdata;
    assign pready    = cur.pready;
    assign pslverr   = cur.pslverr;
    assign mem_req   = cur.mem_req;
    assign mem_we    = cur.mem_we;
    assign mem_addr  = cur.mem_addr;
    assign mem_wdata = cur.mem_wdata;
    assign rx_ready  = cur.rx_ready;

endmodule

// file: testbench/rx_dma_checker_properties.sv
/* Port checker for the receive descriptor DMA.
   Assumes it is bound onto the top module and sees only its ports. */
`timescale 1ns/10ps
// ***********************************************
// Checker
// ***********************************************
module rx_dma_checker (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Memory and stream
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic        mem_ack,
    input wire logic        rx_valid,
    input wire logic        rx_ready
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("apb answer not one cycle after access");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero when idle");
    a_slverr_with: assert property (pslverr |-> pready) else $error("pslverr without pready");
    a_reset_quiet: assert property ($rose(presetn) |-> !mem_req && !pready && !rx_ready)
        else $error("outputs busy after reset");
    a_mem_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we)
        && $stable(mem_wdata)) else $error("memory request changed before ack");
    a_word_align: assert property (mem_req |-> mem_addr[1:0] == 2'h0) else $error("unaligned access");
    a_ready_cause: assert property ($rose(rx_ready) |-> rx_valid) else $error("rx_ready without valid");
    a_take_write: assert property (rx_valid && rx_ready |=> (mem_req && mem_we) || (rx_ready && !mem_req))
        else $error("taken word neither written nor dropped");
    c_mem_write: cover property (mem_req && mem_ack && mem_we);
    c_slverr: cover property (pslverr);
    c_word_taken: cover property (rx_valid && rx_ready);
endmodule
bind rx_descriptor_list_dma rx_dma_checker u_rx_dma_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .rx_valid(rx_valid), .rx_ready(rx_ready));

// file: testbench/host_mem.sv
/* Host physical memory model answering the DMA memory port.
   Assumes word-aligned byte addresses below 0x200. */
`timescale 1ns/10ps
// ***********************************************
// Memory
// ***********************************************
module host_mem (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [31:0] mem_addr,
    input  wire logic [31:0] mem_wdata,
    output logic             mem_ack,
    output logic      [31:0] mem_rdata
);
    logic [31:0] mem [0:127];
    logic [1:0]  dly;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= 1'b0;
            mem_rdata <= 32'h0;
            dly <= 2'h0;
        end else begin
            mem_ack <= 1'b0;
            // Read data is junk outside an answer
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack) begin
                if (dly == 2'h0) begin
                    mem_ack <= 1'b1;
                    // Next answer comes two cycles later when this address has bit 3 set, else promptly
                    dly <= {mem_addr[3], 1'b0};
                    if (mem_we) mem[mem_addr[8:2]] <= mem_wdata;
                    else mem_rdata <= mem[mem_addr[8:2]];
                end else dly <= dly - 2'h1;
            end
        end
    end
endmodule

// file: testbench/rx_descriptor_list_dma_test.sv
/* Self-checking bench for the receive descriptor DMA.
   Assumes the host memory model and the bound port checker. */
`timescale 1ns/10ps
// ***********************************************
// Bench
// ***********************************************
module rx_descriptor_list_dma_test;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rx_valid = 0, rx_last = 0;
    logic rx_ip_checksum_bad = 0, rx_tcp_checksum_bad = 0, pready, pslverr, mem_req, mem_we, mem_ack;
    logic rx_ready, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rx_data = 32'h0, prdata, mem_addr, mem_wdata, mem_rdata, rd;
    int n_fail = 0, n_checks = 0;
    initial forever #20 pclk = ~pclk;
    rx_descriptor_list_dma u_rx_descriptor_list_dma (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_data(rx_data), .rx_last(rx_last),
        .rx_ip_checksum_bad(rx_ip_checksum_bad), .rx_tcp_checksum_bad(rx_tcp_checksum_bad));
    host_mem u_host_mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task timeout;
        n_fail++;
        $display("wait ran out at %0t", $time);
        report_and_stop;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        i = 0;
        do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 20);
        if (i >= 20) timeout;
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task send(input logic [31:0] d, input logic l, input logic ip, input logic tcp);
        int i;
        @(posedge pclk);
        rx_valid <= 1; rx_data <= d; rx_last <= l; rx_ip_checksum_bad <= ip; rx_tcp_checksum_bad <= tcp;
        i = 0;
        do begin @(posedge pclk); i++; end while (rx_ready !== 1'b1 && i < 100);
        if (i >= 100) timeout;
        rx_valid <= 0; rx_data <= ~d;
    endtask
    task wait_frames(input logic [31:0] n);
        int i;
        i = 0;
        do begin apb(0, rx_desc_pkg::frame_count_off, 0); i++; end while (rd !== n && i < 40);
        if (rd !== n) timeout;
        chk(rd, n);
    endtask
    task put_desc(input int a, input logic [31:0] w0, w1, w2, w3);
        u_host_mem.mem[a / 4] = w0; u_host_mem.mem[a / 4 + 1] = w1;
        u_host_mem.mem[a / 4 + 2] = w2; u_host_mem.mem[a / 4 + 3] = w3;
    endtask
    task test_regs;
        apb(0, rx_desc_pkg::ctrl_off, 0); chk(rd, 32'h0);
        apb(0, rx_desc_pkg::status_off, 0); chk(rd, 32'h4);
        apb(1, rx_desc_pkg::tx_list_base_off, 32'h200); apb(0, rx_desc_pkg::tx_list_base_off, 0);
        chk(rd, 32'h200);
        apb(1, 8'h1c, 32'hffff_ffff); chk({31'h0, err}, 32'h1); chk(rd, 32'h0);
        apb(1, rx_desc_pkg::rx_list_base_off, 32'h40); apb(0, rx_desc_pkg::cur_desc_off, 0);
        chk(rd, 32'h40);
        $display("test_regs done");
    endtask
    task test_single;
        put_desc(32'h40, 32'h8000_0000, 32'h10, 32'h100, 32'h60);
        put_desc(32'h60, 32'h0, 32'h0, 32'h140, 32'h80);
        apb(1, rx_desc_pkg::ctrl_off, 32'h1);
        send(32'h1111_0001, 0, 0, 0); send(32'h2222_0002, 1, 1, 0);
        wait_frames(1);
        chk(u_host_mem.mem[64], 32'h1111_0001); chk(u_host_mem.mem[65], 32'h2222_0002);
        chk(u_host_mem.mem[16], 32'h7000_0000);
        repeat (10) @(posedge pclk);
        apb(0, rx_desc_pkg::status_off, 0); chk(rd & 32'h2, 32'h2);
        apb(0, rx_desc_pkg::cur_desc_off, 0); chk(rd, 32'h60);
        chk(u_host_mem.mem[24], 32'h0);
        $display("test_single done");
    endtask
    task test_chain;
        put_desc(32'h60, 32'h8000_0000, 32'h0, 32'h140, 32'h80);
        put_desc(32'h80, 32'h8000_0000, 32'h8, 32'h180, 32'ha0);
        put_desc(32'ha0, 32'h8000_0000, 32'h8, 32'h1c0, 32'h40);
        apb(1, rx_desc_pkg::ctrl_off, 32'h3); apb(1, rx_desc_pkg::poll_off, 0);
        send(32'h0a0a_0001, 0, 0, 0); send(32'h0b0b_0002, 0, 0, 0); send(32'h0c0c_0003, 1, 0, 1);
        wait_frames(2);
        chk(u_host_mem.mem[24], 32'h0);
        chk(u_host_mem.mem[32], 32'h4000_0000);
        chk(u_host_mem.mem[40], 32'h2800_0000);
        chk(u_host_mem.mem[96], 32'h0a0a_0001); chk(u_host_mem.mem[97], 32'h0b0b_0002);
        chk(u_host_mem.mem[112], 32'h0c0c_0003);
        apb(0, rx_desc_pkg::cur_desc_off, 0); chk(rd, 32'h40);
        $display("test_chain done");
    endtask
    task test_drop;
        put_desc(32'h1e0, 32'h0, 32'h0, 32'h0, 32'h0);
        put_desc(32'h40, 32'h8000_0000, 32'h4, 32'h1e0, 32'h60);
        apb(1, rx_desc_pkg::ctrl_off, 32'h1); apb(1, rx_desc_pkg::poll_off, 0);
        send(32'h0d0d_0001, 0, 0, 0); send(32'h0e0e_0002, 1, 1, 0);
        wait_frames(3);
        chk(u_host_mem.mem[120], 32'h0d0d_0001); chk(u_host_mem.mem[121], 32'h0);
        chk(u_host_mem.mem[16], 32'h7000_0000);
        $display("test_drop done");
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        test_regs;
        test_single;
        test_chain;
        test_drop;
        report_and_stop;
    end
endmodule
